/* ep0_consts.svh */
// Constants for the default control endpoint transaction block.
// Assumes a 32-bit AXI4-Lite register bus and a token-level link front end.
// Function
// - Status raised for good SETUP, NAK, error, IN ACK and new OUT data; none for STALL or PING ACK
// - FIFO fill decides transfer, no firmware help
// - Firmware drains FIFO, OUT accepted again
// - Firmware fills FIFO, IN served again
// - Status flags drive masked interrupt output
// - Direction bit selects data/status stage direction
// - Descriptor reply answers data stage automatically
// - Reply starts at address, returns exact count
// - Protect bit blocks refuse/halt bit writes
// - SETUP flag sets protect; CPU clears it
// - Short IN enable cleared after short IN
// - Separate IN/OUT toggles, initialised on SETUP
// - Toggle set forces one, clear forces zero
// - Refuse bit answers NAK regardless of FIFO
// - Halt bit answers STALL
// - Auto refuse sets OUT refuse after OUT
// - SETUP received flag raised
// - Separate ACK, NAK, error flags per direction; short flag for OUT only
// - Descriptor done flag at data stage end
// - SETUP stores eight bytes then ACKs
// - SETUP sets refuse, clears halt both directions
`ifndef EP0_CONSTS_SVH
`define EP0_CONSTS_SVH
// ====================================================
// Register byte offsets
`define REG_CONTROL    12'h000
`define REG_CTRL_IN    12'h004
`define REG_CTRL_OUT   12'h008
`define REG_SETUP_CTL  12'h00c
`define REG_STATUS     12'h010
`define REG_MASK       12'h014
`define REG_DESC_ADDR  12'h018
`define REG_DESC_SIZE  12'h01c
`define REG_MAX_PKT    12'h020
`define REG_SETUP_LO   12'h024
`define REG_SETUP_HI   12'h028
// ====================================================
// Direction control fields
`define B_REFUSE      0
`define B_HALT        1
`define B_TOG_ONE     2
`define B_TOG_ZERO    3
`define B_TOG_STATE   4
`define B_SHORT_EN    5
`define B_AUTO_REFUSE 6
// Status flag positions
`define S_OUT_SHORT   0
`define S_IN_ACK      1
`define S_OUT_ACK     2
`define S_IN_NAK      3
`define S_OUT_NAK     4
`define S_IN_ERR      5
`define S_OUT_ERR     6
`define S_SETUP       7
`define S_DESC_DONE   8
`define MAX_PKT_RESET 7'h40
`endif

/* ep0_pkg.sv */
// Types for the default control endpoint transaction block.
// Assumes ep0_consts.svh sits beside it.
`default_nettype none
package ep0_pkg;
  typedef enum logic [1:0] {
    HS_ACK   = 2'b00,
    HS_NAK   = 2'b01,
    HS_STALL = 2'b10,
    HS_NONE  = 2'b11
  } hs_t;
  typedef enum logic [1:0] {
    TK_SETUP = 2'b00,
    TK_IN    = 2'b01,
    TK_OUT   = 2'b10,
    TK_PING  = 2'b11
  } tok_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESP = 2'b01
  } state_t;
  // One token as presented by the serial engine
  typedef struct packed {
    logic       valid;
    tok_t       kind;
    logic       pid_odd;
    logic [6:0] out_len;
    logic       crc_err;
    logic [63:0] setup_data;
  } token_t;
  typedef struct packed {
    logic [1:0] refuse;
    logic [1:0] halt;
    logic [1:0] toggle;
    logic       short_en;
    logic       auto_refuse;
    logic       direction;
    logic       desc_en;
    logic       protect;
    logic [8:0] flags;
    logic [8:0] mask;
    logic [15:0] desc_addr;
    logic [15:0] desc_size;
    logic [15:0] desc_left;
    logic       desc_busy;
    logic [6:0] max_pkt;
    logic [63:0] setup_bytes;
    state_t     state;
    hs_t        hs;
    logic       hs_valid;
    logic [6:0] tx_len;
    logic       tx_pid_odd;
    logic [15:0] tx_addr;
    logic       tx_from_desc;
    logic [6:0] fifo_pop_len;
    logic       fifo_commit;
    logic       awt;
    logic       wt;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_all_t;
endpackage
`default_nettype wire

/* ep0_txn_ctrl.sv */
// Transaction control for the default control endpoint.
// Assumes a serial engine presenting one decoded token per valid pulse and a FIFO reporting fill/free counts.
`default_nettype none
`include "ep0_consts.svh"
module ep0_txn_ctrl
  import ep0_pkg::*;
#(
  parameter int FIFO_W = 16
) (
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  input  wire  logic [11:0]       s_axi_awaddr,
  input  wire  logic              s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire  logic [31:0]       s_axi_wdata,
  input  wire  logic [3:0]        s_axi_wstrb,
  input  wire  logic              s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire  logic              s_axi_bready,
  input  wire  logic [11:0]       s_axi_araddr,
  input  wire  logic              s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire  logic              s_axi_rready,
  input  wire  token_t            token,
  input  wire  logic [FIFO_W-1:0] fifo_fill,
  input  wire  logic [FIFO_W-1:0] fifo_free,
  input  wire  logic              in_done,
  input  wire  logic              in_timeout,
  output hs_t                     handshake,
  output logic                    handshake_valid,
  output logic [6:0]              tx_len,
  output logic                    tx_pid_odd,
  output logic [15:0]             tx_addr,
  output logic                    tx_from_desc,
  output logic [6:0]              fifo_pop_len,
  output logic                    fifo_commit,
  output logic                    irq
);
  // ====================================================
  // State
  state_all_t q;
  state_all_t d;
  logic       dir_in;
  logic       fw_ctl_ok;
  logic       wr_go;
  logic       rd_go;
  logic [8:0] set_flags;

  function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] r);
    return a[11:2] == r[11:2];
  endfunction

  assign dir_in    = q.direction;
  assign fw_ctl_ok = !q.protect;
  assign wr_go     = q.awt && q.wt && !q.bvalid;
  assign rd_go     = s_axi_arvalid && !q.rvalid;

  always_comb begin
    logic [6:0]  avail;
    logic [15:0] chunk;
    d           = q;
    avail       = 7'h00;
    chunk       = 16'h0000;
    set_flags   = 9'h000;
    d.hs_valid  = 1'b0;
    d.fifo_commit = 1'b0;
    // ====================================================
    // Token handling
    if (token.valid) begin
      d.hs_valid = 1'b1;
      case (token.kind)
        TK_SETUP: begin
          if (token.crc_err) begin
            d.hs_valid = 1'b0;                                  // No reply, no status on bad SETUP
          end else begin
            d.setup_bytes = token.setup_data;
            d.hs          = HS_ACK;
            d.refuse      = 2'b11;
            d.halt        = 2'b00;
            d.toggle      = 2'b11;
            d.desc_busy   = 1'b0;
            set_flags[`S_SETUP] = 1'b1;
          end
        end
        TK_IN: begin
          if (!dir_in || q.halt[1]) begin
            d.hs = HS_STALL;
          end else if (q.refuse[1]) begin
            d.hs = HS_NAK;
            set_flags[`S_IN_NAK] = 1'b1;
          end else if (q.desc_en) begin
            // Descriptor data stays resident, so the reply needs no FIFO check
            if (!q.desc_busy) begin
              d.desc_left = q.desc_size;
              d.tx_addr   = q.desc_addr;
              chunk       = q.desc_size;
            end else begin
              chunk       = q.desc_left;
            end
            d.tx_len       = (chunk > {9'h000, q.max_pkt}) ? q.max_pkt : chunk[6:0];
            d.tx_from_desc = 1'b1;
            d.desc_busy    = 1'b1;
            d.hs           = HS_NONE;
            d.tx_pid_odd   = q.toggle[1];
          end else begin
            avail = (fifo_fill >= FIFO_W'(q.max_pkt)) ? q.max_pkt : fifo_fill[6:0];
            if (avail == q.max_pkt || (q.short_en && fifo_fill < FIFO_W'(q.max_pkt))) begin
              d.tx_len       = avail;
              d.tx_from_desc = 1'b0;
              d.tx_pid_odd   = q.toggle[1];
              d.hs           = HS_NONE;
            end else begin
              d.hs = HS_NAK;
              set_flags[`S_IN_NAK] = 1'b1;
            end
          end
          if (d.hs == HS_NONE) begin
            d.state = ST_RESP;
          end
        end
        TK_OUT, TK_PING: begin
          if (token.kind == TK_OUT && token.crc_err) begin
            // Corrupt data is never answered, whatever the refuse or halt state
            d.hs_valid = 1'b0;
            set_flags[`S_OUT_ERR] = 1'b1;
          end else if (dir_in || q.halt[0]) begin
            d.hs = HS_STALL;
          end else if (q.refuse[0] || fifo_free < FIFO_W'(q.max_pkt)) begin
            d.hs = HS_NAK;
            set_flags[`S_OUT_NAK] = 1'b1;
          end else if (token.kind == TK_PING) begin
            d.hs = HS_ACK;
          end else begin
            d.hs = HS_ACK;
            if (token.pid_odd == q.toggle[0]) begin
              d.toggle[0]     = ~q.toggle[0];
              d.fifo_pop_len  = token.out_len;
              d.fifo_commit   = 1'b1;
              set_flags[`S_OUT_ACK] = 1'b1;
              if (token.out_len < q.max_pkt) begin
                set_flags[`S_OUT_SHORT] = 1'b1;
              end
              if (q.auto_refuse) begin
                d.refuse[0] = 1'b1;
              end
            end
          end
        end
        default: d.hs_valid = 1'b0;
      endcase
    end
    // ====================================================
    // IN data phase outcome
    if (q.state == ST_RESP && (in_done || in_timeout)) begin
      d.state = ST_IDLE;
      if (in_timeout) begin
        set_flags[`S_IN_ERR] = 1'b1;
      end else begin
        set_flags[`S_IN_ACK] = 1'b1;
        d.toggle[1] = ~q.toggle[1];
        if (q.tx_len < q.max_pkt) begin
          d.short_en = 1'b0;
        end
        if (q.tx_from_desc) begin
          d.desc_left = q.desc_left - {9'h000, q.tx_len};
          d.tx_addr   = q.tx_addr + {9'h000, q.tx_len};
          if (q.tx_len < q.max_pkt) begin
            d.desc_busy = 1'b0;
            d.desc_en   = 1'b0;
            set_flags[`S_DESC_DONE] = 1'b1;
          end
        end else begin
          d.fifo_pop_len = q.tx_len;
          d.fifo_commit  = 1'b1;
        end
      end
    end
    // ====================================================
    // Register writes
    if (wr_go) begin
      d.awt    = 1'b0;
      d.wt     = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = 2'b00;
      if (wr_hit(q.awaddr, `REG_CONTROL)) begin
        d.direction = q.wdata[0];
        d.desc_en   = q.wdata[1];
        if (q.wdata[1]) begin
          d.desc_busy = 1'b0;
        end
      end else if (wr_hit(q.awaddr, `REG_CTRL_IN) || wr_hit(q.awaddr, `REG_CTRL_OUT)) begin
        for (int i = 0; i < 2; i++) begin
          if (wr_hit(q.awaddr, i == 1 ? `REG_CTRL_IN : `REG_CTRL_OUT)) begin
            if (fw_ctl_ok) begin
              d.refuse[i] = q.wdata[`B_REFUSE];
              d.halt[i]   = q.wdata[`B_HALT];
            end
            if (q.wdata[`B_TOG_ONE]) begin
              d.toggle[i] = 1'b1;
            end else if (q.wdata[`B_TOG_ZERO]) begin
              d.toggle[i] = 1'b0;
            end
          end
        end
        if (wr_hit(q.awaddr, `REG_CTRL_IN)) begin
          d.short_en = q.wdata[`B_SHORT_EN];
        end else begin
          d.auto_refuse = q.wdata[`B_AUTO_REFUSE];
        end
      end else if (wr_hit(q.awaddr, `REG_SETUP_CTL)) begin
        d.protect = q.wdata[0];
      end else if (wr_hit(q.awaddr, `REG_STATUS)) begin
        d.flags = q.flags & ~q.wdata[8:0];
      end else if (wr_hit(q.awaddr, `REG_MASK)) begin
        d.mask = q.wdata[8:0];
      end else if (wr_hit(q.awaddr, `REG_DESC_ADDR)) begin
        d.desc_addr = q.wdata[15:0];
      end else if (wr_hit(q.awaddr, `REG_DESC_SIZE)) begin
        d.desc_size = q.wdata[15:0];
      end else if (wr_hit(q.awaddr, `REG_MAX_PKT)) begin
        d.max_pkt = q.wdata[6:0];
      end else begin
        d.bresp = 2'b10;
      end
    end
    // Hardware set wins over a write-one clear in the same cycle
    d.flags = d.flags | set_flags;
    if (set_flags[`S_SETUP]) begin
      d.protect = 1'b1;
    end
    if (s_axi_awvalid && !q.awt) begin
      d.awt    = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wt) begin
      d.wt    = 1'b1;
      d.wdata = s_axi_wdata;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // ====================================================
    // Register reads
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp  = 2'b00;
      d.rdata  = 32'h0000_0000;
      case ({s_axi_araddr[11:2], 2'b00})
        `REG_CONTROL:   d.rdata[1:0] = {q.desc_en, q.direction};
        `REG_CTRL_IN:   d.rdata[5:0] = {q.short_en, q.toggle[1], 2'b00, q.halt[1], q.refuse[1]};
        `REG_CTRL_OUT:  d.rdata[6:0] = {q.auto_refuse, 1'b0, q.toggle[0], 2'b00, q.halt[0], q.refuse[0]};
        `REG_SETUP_CTL: d.rdata[0]   = q.protect;
        `REG_STATUS:    d.rdata[8:0] = q.flags;
        `REG_MASK:      d.rdata[8:0] = q.mask;
        `REG_DESC_ADDR: d.rdata[15:0] = q.desc_addr;
        `REG_DESC_SIZE: d.rdata[15:0] = q.desc_size;
        `REG_MAX_PKT:   d.rdata[6:0] = q.max_pkt;
        `REG_SETUP_LO:  d.rdata = q.setup_bytes[31:0];
        `REG_SETUP_HI:  d.rdata = q.setup_bytes[63:32];
        default:        d.rresp = 2'b10;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.max_pkt <= `MAX_PKT_RESET;
      q.hs      <= HS_NONE;
      q.state   <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ====================================================
  // Outputs
  assign s_axi_awready   = !q.awt;
  assign s_axi_wready    = !q.wt;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_arready   = !q.rvalid;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rdata     = q.rdata;
  assign s_axi_rresp     = q.rresp;
  assign handshake       = q.hs;
  assign handshake_valid = q.hs_valid && q.hs != HS_NONE;
  assign tx_len          = q.tx_len;
  assign tx_pid_odd      = q.tx_pid_odd;
  assign tx_addr         = q.tx_addr;
  assign tx_from_desc    = q.tx_from_desc;
  assign fifo_pop_len    = q.fifo_pop_len;
  assign fifo_commit     = q.fifo_commit;
  assign irq             = |(q.flags & q.mask);
endmodule // ep0_txn_ctrl
`default_nettype wire

/* ep0_txn_ctrl_checker.sv */
// Port checker for the control endpoint transaction block.
// Assumes ep0_pkg is compiled first; attached to every ep0_txn_ctrl by bind.
`default_nettype none
module ep0_txn_ctrl_checker import ep0_pkg::*; (
  input wire logic   aclk,
  input wire logic   aresetn,
  input wire token_t token,
  input wire hs_t    handshake,
  input wire logic   handshake_valid,
  input wire logic   s_axi_awvalid,
  input wire logic   s_axi_awready,
  input wire logic   s_axi_wvalid,
  input wire logic   s_axi_wready,
  input wire logic   s_axi_bvalid,
  input wire logic   s_axi_arvalid,
  input wire logic   s_axi_arready,
  input wire logic   s_axi_rvalid,
  input wire logic   s_axi_rready
);
  // ====================================================
  // Link answers
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SETUP_ACK: assert property (token.valid && token.kind == TK_SETUP && !token.crc_err |=>
    handshake_valid && handshake == HS_ACK) else $error("setup not acked");
  AST_HS_CAUSE: assert property (handshake_valid |-> $past(token.valid))
    else $error("handshake without token");
  AST_HS_PULSE: assert property (handshake_valid |=> !handshake_valid)
    else $error("handshake longer than one cycle");
  AST_PING_ANSWER: assert property (token.valid && token.kind == TK_PING |=>
    handshake_valid && handshake != HS_NONE) else $error("ping unanswered");
  AST_CRC_SILENT: assert property (token.valid && token.crc_err && token.kind inside {TK_SETUP, TK_OUT}
    |=> !handshake_valid) else $error("answered a corrupt packet");
  // ====================================================
  // Register bus
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  cover property (token.valid && token.kind == TK_SETUP ##1 handshake_valid);
  cover property (token.valid && token.kind == TK_IN ##1 !handshake_valid);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // ep0_txn_ctrl_checker
bind ep0_txn_ctrl ep0_txn_ctrl_checker u_ep0_txn_ctrl_checker (.aclk, .aresetn, .token, .handshake,
  .handshake_valid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* ep0_host_model.sv */
// Behavioural bus host: issues one token per frame, acknowledges IN data.
// Assumes the bench calls send only after the previous answer.
`default_nettype none
module ep0_host_model import ep0_pkg::*; (
  input  wire logic aclk,
  input  wire logic handshake_valid,
  output var token_t token,
  output logic      in_done,
  output logic      in_timeout
);
  int   dly  = 1;
  logic drop = 1'h0;
  initial begin
    token = '0;
    in_done = 1'h0;
    in_timeout = 1'h0;
  end
  // Valid is cleared after one cycle and the idle payload inverted, so a stale token never looks valid by accident
  task automatic send(input tok_t k, input logic odd, input logic [6:0] len, input logic crc, input logic [63:0] d);
    token <= '{valid: 1'h1, kind: k, pid_odd: odd, out_len: len, crc_err: crc, setup_data: d};
    @(posedge aclk);
    token <= {1'h0, ~token[74:0]};
    @(posedge aclk);
    if (k == TK_IN && !handshake_valid) begin
      repeat (dly) @(posedge aclk);
      in_done <= !drop;
      in_timeout <= drop;
      @(posedge aclk);
      in_done <= 1'h0;
      in_timeout <= 1'h0;
    end
  endtask
endmodule // ep0_host_model
`default_nettype wire

/* test_ep0_txn_ctrl.sv */
// Self-checking bench for ep0_txn_ctrl.
// Assumes ep0_pkg, the checker and the host model are compiled first.
`default_nettype none
`include "ep0_consts.svh"
module test_ep0_txn_ctrl import ep0_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, in_done, in_timeout;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, r, seed = 32'h9cc2ed35;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, handshake_valid;
  logic tx_pid_odd, tx_from_desc, fifo_commit, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] fifo_fill = '0, fifo_free = '0, tx_addr, da;
  logic [6:0] tx_len, fifo_pop_len;
  logic [63:0] sd;
  token_t token;
  hs_t handshake;
  logic [33:0] q_hs[$], q_b[$], q_pop[$];
  logic [67:0] q_r[$];
  int num_errors = 0, check_count = 0;
  always #4 aclk = ~aclk;
  ep0_txn_ctrl u_ep0_txn_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .token,
    .fifo_fill, .fifo_free, .in_done, .in_timeout, .handshake, .handshake_valid, .tx_len, .tx_pid_odd,
    .tx_addr, .tx_from_desc, .fifo_pop_len, .fifo_commit, .irq);
  ep0_host_model u_ep0_host_model (.aclk, .handshake_valid, .token, .in_done, .in_timeout);
  // ====================================================
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    check_count++;
    if (s !== e || $isunknown(e)) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stuck();
    num_errors++;
    end_sim();
  endtask
  // Each channel is released on its own ready; response ready held until answered
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    q_b.push_back(34'(e));
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'h0;
        return;
      end
    end
    stuck();
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e, input logic [33:0] m = '1);
    q_r.push_back({m, e & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'h0;
        return;
      end
    end
    stuck();
  endtask
  task automatic tok(input tok_t k, input hs_t e, input logic odd = 1'h0, input logic crc = 1'h0);
    if (e != HS_NONE) q_hs.push_back(34'(e));
    sd = {rnd(), rnd()};
    u_ep0_host_model.send(k, odd, 7'h40, crc, sd);
  endtask
  // ====================================================
  // Result watcher
  always @(posedge aclk) begin
    logic [67:0] e;
    if (handshake_valid) chk("handshake", q_hs.size() ? q_hs.pop_front() : 'x, 34'(handshake));
    if (s_axi_bvalid && s_axi_bready) chk("bresp", q_b.size() ? q_b.pop_front() : 'x, 34'(s_axi_bresp));
    if (fifo_commit) chk("fifo_pop_len", q_pop.size() ? q_pop.pop_front() : 'x, 34'(fifo_pop_len));
    if (s_axi_rvalid && s_axi_rready) begin
      e = q_r.size() ? q_r.pop_front() : 'x;
      chk("rdata", e[33:0], {s_axi_rresp, s_axi_rdata} & e[67:34]);
    end
  end
  initial begin
    repeat (30000) @(posedge aclk);
    stuck();
  end
  // ====================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`REG_MAX_PKT, 34'h40);
    rd(`REG_STATUS, 34'h0);
    rd(12'h0fc, 34'h200000000);
    wr(12'h0fc, 32'h0, 2'h2);
    wr(`REG_MASK, 32'h80);
    tok(TK_SETUP, HS_ACK);
    rd(`REG_SETUP_LO, 34'(sd[31:0]));
    rd(`REG_SETUP_HI, 34'(sd[63:32]));
    rd(`REG_STATUS, 34'h80, 34'h80);
    chk("irq", 34'h1, 34'(irq));
    rd(`REG_SETUP_CTL, 34'h1, 34'h1);
    rd(`REG_CTRL_IN, 34'h11, 34'h13);
    rd(`REG_CTRL_OUT, 34'h11, 34'h13);
    wr(`REG_CTRL_IN, 32'h2);
    rd(`REG_CTRL_IN, 34'h1, 34'h3);
    wr(`REG_STATUS, 32'h80);
    @(posedge aclk);
    chk("irq", 34'h0, 34'(irq));
    wr(`REG_SETUP_CTL, 32'h0);
    rd(`REG_SETUP_CTL, 34'h0, 34'h1);
    r = rnd();
    u_ep0_host_model.dly = 1 + int'(r[3:2]);
    fifo_fill <= 16'h40 + 16'(r[5:0]);
    wr(`REG_CONTROL, 32'h1);
    wr(`REG_CTRL_OUT, 32'h0);
    wr(`REG_CTRL_IN, 32'h1);
    tok(TK_IN, HS_NAK);
    wr(`REG_CTRL_IN, 32'h2);
    tok(TK_IN, HS_STALL);
    tok(TK_OUT, HS_STALL);
    wr(`REG_CTRL_IN, 32'h0);
    fifo_fill <= 16'(r[5:0]);
    tok(TK_IN, HS_NAK);
    wr(`REG_CTRL_IN, 32'h20);
    q_pop.push_back(34'(r[5:0]));
    tok(TK_IN, HS_NONE);
    chk("tx_len", 34'({2'h2, r[5:0]}), 34'({tx_pid_odd, tx_len}));
    rd(`REG_CTRL_IN, 34'h0, 34'h20);
    rd(`REG_STATUS, 34'h2, 34'h2);
    u_ep0_host_model.drop = 1'h1;
    wr(`REG_CTRL_IN, 32'h20);
    tok(TK_IN, HS_NONE);
    u_ep0_host_model.drop = 1'h0;
    rd(`REG_STATUS, 34'h20, 34'h20);
    wr(`REG_CONTROL, 32'h0);
    fifo_free <= 16'h40 + 16'(r[11:6]);
    wr(`REG_CTRL_OUT, 32'h8);
    rd(`REG_CTRL_OUT, 34'h0, 34'h10);
    wr(`REG_CTRL_OUT, 32'h44);
    rd(`REG_CTRL_OUT, 34'h50, 34'h53);
    q_pop.push_back(34'h40);
    tok(TK_OUT, HS_ACK, 1'h1);
    rd(`REG_CTRL_OUT, 34'h1, 34'h1);
    rd(`REG_STATUS, 34'h4, 34'h4);
    tok(TK_PING, HS_NAK);
    tok(TK_OUT, HS_NAK);
    rd(`REG_STATUS, 34'h10, 34'h10);
    wr(`REG_CTRL_OUT, 32'h0);
    fifo_free <= 16'(r[11:6]);
    tok(TK_OUT, HS_NAK);
    tok(TK_OUT, HS_NONE, 1'h0, 1'h1);
    rd(`REG_STATUS, 34'h40, 34'h40);
    wr(`REG_CTRL_OUT, 32'h2);
    tok(TK_PING, HS_STALL);
    // Descriptor of one full packet plus a short tail
    da = 16'(rnd());
    fifo_fill <= 16'h46;
    wr(`REG_DESC_ADDR, {16'h0, da});
    wr(`REG_DESC_SIZE, 32'h46);
    wr(`REG_CONTROL, 32'h3);
    tok(TK_IN, HS_NONE);
    chk("tx", 34'({1'h1, 7'h40, da}), 34'({tx_from_desc, tx_len, tx_addr}));
    tok(TK_IN, HS_NONE);
    chk("tx", 34'({1'h1, 7'h06, da + 16'h40}), 34'({tx_from_desc, tx_len, tx_addr}));
    rd(`REG_STATUS, 34'h100, 34'h100);
    rd(`REG_CONTROL, 34'h1, 34'h3);
    end_sim();
  end
endmodule // test_ep0_txn_ctrl
`default_nettype wire
